// [cic_defines.svh]
// Constants for the instruction class execution core
`ifndef CIC_DEFINES_SVH
`define CIC_DEFINES_SVH
// ==========================================
// Reset values, fixed address bytes and stack pointer step
`define CIC_RESET_PC 16'h0100
`define CIC_RESET_SP 8'hff
`define CIC_STACK_HI 8'h00
`define CIC_DIRECT_HI 8'h00
`define CIC_SP_STEP 8'h01
// ==========================================
// Opcode groups (upper nibble)
`define CIC_G_BRBIT 4'h0
`define CIC_G_BITOP 4'h1
`define CIC_G_REL 4'h2
`define CIC_G_RMWD 4'h3
`define CIC_G_RMWA 4'h4
`define CIC_G_RMWX 4'h5
`define CIC_G_CTL0 4'h8
`define CIC_G_CTL1 4'h9
`define CIC_G_IMM 4'ha
`define CIC_G_DIR 4'hb
`define CIC_G_EXT 4'hc
// ==========================================
// Whole opcodes
`define CIC_OP_MULTIPLY 8'h42
`define CIC_OP_RTS 8'h81
`define CIC_OP_STOP 8'h8e
`define CIC_OP_WAIT 8'h8f
`define CIC_OP_COPY_AX 8'h97
`define CIC_OP_CLC 8'h98
`define CIC_OP_SEC 8'h99
`define CIC_OP_CLI 8'h9a
`define CIC_OP_SEI 8'h9b
`define CIC_OP_COPY_XA 8'h9f
`define CIC_OP_PIN_HIGH 8'h2f
// ==========================================
// Read-modify-write functions (lower nibble)
`define CIC_RMW_NEG 4'h0
`define CIC_RMW_COM 4'h3
`define CIC_RMW_LSR 4'h4
`define CIC_RMW_ROTR 4'h6
`define CIC_RMW_ASR 4'h7
`define CIC_RMW_LSL 4'h8
`define CIC_RMW_ROTL 4'h9
`define CIC_RMW_DEC 4'ha
`define CIC_RMW_INC 4'hc
`define CIC_RMW_TEST 4'hd
`define CIC_RMW_CLR 4'hf
// ==========================================
// Register/memory functions (lower nibble)
`define CIC_RM_SUB 4'h0
`define CIC_RM_COMPARE 4'h1
`define CIC_RM_SBC 4'h2
`define CIC_RM_CPX 4'h3
`define CIC_RM_AND 4'h4
`define CIC_RM_BIT 4'h5
`define CIC_RM_LDA 4'h6
`define CIC_RM_STA 4'h7
`define CIC_RM_EOR 4'h8
`define CIC_RM_ADC 4'h9
`define CIC_RM_ORA 4'ha
`define CIC_RM_ADD 4'hb
`define CIC_RM_JUMP 4'hc
`define CIC_RM_CALL 4'hd
`define CIC_RM_LDX 4'he
`define CIC_RM_STX 4'hf
`endif

// [cic_pkg.sv]
// Types shared by the instruction class execution core
`default_nettype none
package cic_pkg;
  typedef enum logic [3:0] {
    S_FETCH, S_OP, S_B1, S_B2, S_MEM, S_EXEC, S_PUSH, S_POP1, S_POP2, S_HALT
  } cic_state_t;
  typedef struct packed {
    logic h;
    logic i;
    logic n;
    logic z;
    logic c;
  } cic_ccr_t;
  typedef struct packed {
    cic_state_t st;
    logic [15:0] pc;
    logic [7:0] sp;
    logic [7:0] a;
    logic [7:0] x;
    logic [7:0] op;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] m;
    cic_ccr_t condition_flags_reg;
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
    logic osc_stop;
    logic clk_stop;
    logic irq_en;
    logic pin_s1;
    logic pin_s2;
  } cic_core_t;
endpackage
`default_nettype wire

// [cic_alu_if.sv]
// Operand and result bundle between the core and its arithmetic unit
`timescale 1ns/1ps
`default_nettype none
interface cic_alu_if;
  logic rmw;
  logic [3:0] fn;
  logic [7:0] a;
  logic [7:0] m;
  logic cin;
  logic [7:0] res;
  logic cout;
  logic cupd;
  logic hout;
  logic hupd;
  modport alu (input rmw, fn, a, m, cin, output res, cout, cupd, hout, hupd);
  modport core (output rmw, fn, a, m, cin, input res, cout, cupd, hout, hupd);
endinterface
`default_nettype wire

// [cic_alu.sv]
// Arithmetic unit for read-modify-write and register/memory operations
`timescale 1ns/1ps
`default_nettype none
`include "cic_defines.svh"
module cic_alu (
  cic_alu_if.alu p
);
  import cic_pkg::*;
  logic [8:0] sum;
  logic [4:0] hs;
  logic cx;
  // ==========================================
  // Function select
  always_comb begin
    sum = 9'h000;
    hs = 5'h00;
    cx = 1'b0;
    p.res = p.m;
    p.cout = p.cin;
    p.cupd = 1'b0;
    p.hout = 1'b0;
    p.hupd = 1'b0;
    if (p.rmw) begin
      p.cupd = 1'b1;
      case (p.fn)
        `CIC_RMW_NEG: begin
          p.res = 8'h00 - p.m;
          p.cout = (p.m != 8'h00);
        end
        `CIC_RMW_COM: begin
          p.res = ~p.m;
          p.cout = 1'b1;
        end
        `CIC_RMW_LSR: begin
          p.res = {1'b0, p.m[7:1]};
          p.cout = p.m[0];
        end
        `CIC_RMW_ROTR: begin
          p.res = {p.cin, p.m[7:1]};
          p.cout = p.m[0];
        end
        `CIC_RMW_ASR: begin
          p.res = {p.m[7], p.m[7:1]};
          p.cout = p.m[0];
        end
        `CIC_RMW_LSL: begin
          p.res = {p.m[6:0], 1'b0};
          p.cout = p.m[7];
        end
        `CIC_RMW_ROTL: begin
          p.res = {p.m[6:0], p.cin};
          p.cout = p.m[7];
        end
        `CIC_RMW_DEC: begin
          p.res = p.m - 8'h01;
          p.cupd = 1'b0;
        end
        `CIC_RMW_INC: begin
          p.res = p.m + 8'h01;
          p.cupd = 1'b0;
        end
        `CIC_RMW_CLR: begin
          p.res = 8'h00;
          p.cupd = 1'b0;
        end
        default: p.cupd = 1'b0;
      endcase
    end else begin
      case (p.fn)
        `CIC_RM_SUB, `CIC_RM_COMPARE, `CIC_RM_SBC, `CIC_RM_CPX: begin
          cx = p.cin & (p.fn == `CIC_RM_SBC);
          sum = {1'b0, p.a} - {1'b0, p.m} - {8'h00, cx};
          p.res = sum[7:0];
          p.cout = sum[8];
          p.cupd = 1'b1;
        end
        `CIC_RM_ADD, `CIC_RM_ADC: begin
          cx = p.cin & (p.fn == `CIC_RM_ADC);
          sum = {1'b0, p.a} + {1'b0, p.m} + {8'h00, cx};
          hs = {1'b0, p.a[3:0]} + {1'b0, p.m[3:0]} + {4'h0, cx};
          p.res = sum[7:0];
          p.cout = sum[8];
          p.cupd = 1'b1;
          p.hout = hs[4];
          p.hupd = 1'b1;
        end
        `CIC_RM_AND, `CIC_RM_BIT: p.res = p.a & p.m;
        `CIC_RM_EOR: p.res = p.a ^ p.m;
        `CIC_RM_ORA: p.res = p.a | p.m;
        `CIC_RM_STA, `CIC_RM_STX: p.res = p.a;
        default: p.res = p.m;
      endcase
    end
  end
endmodule
`default_nettype wire

// [cic_core.sv]
// 8-bit core executing register/memory, read-modify-write, branch, bit and control classes
`timescale 1ns/1ps
`default_nettype none
`include "cic_defines.svh"
module cic_core (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic irq_pin_n_in,
  input wire logic [7:0] mem_rdata_in,
  output logic [15:0] mem_addr_out,
  output logic mem_rd_out,
  output logic mem_wr_out,
  output logic [7:0] mem_wdata_out,
  output logic [15:0] pc_out,
  output logic [7:0] acc_out,
  output logic [7:0] idx_out,
  output var cic_pkg::cic_ccr_t ccr_out,
  output logic osc_stop_out,
  output logic cpu_clk_stop_out,
  output logic irq_pin_en_out
);
  import cic_pkg::*;
  cic_core_t r;
  cic_core_t r_nxt;
  cic_alu_if alu_bus();
  logic [3:0] hi;
  logic [3:0] lo;
  logic [15:0] ea;
  logic bit_t;
  logic bt_take;
  logic [15:0] bt_tgt;
  logic rel_take;
  logic [15:0] rel_tgt;
  logic [15:0] prod;
  logic [7:0] mask;
  logic ex;
  // ==========================================
  // Decode helpers
  function automatic logic [1:0] op_len(input logic [7:0] o);
    case (o[7:4])
      `CIC_G_BRBIT, `CIC_G_EXT: op_len = 2'h2;
      `CIC_G_BITOP, `CIC_G_REL, `CIC_G_RMWD, `CIC_G_IMM, `CIC_G_DIR: op_len = 2'h1;
      default: op_len = 2'h0;
    endcase
  endfunction
  function automatic logic needs_mem(input logic [7:0] o);
    case (o[7:4])
      `CIC_G_BRBIT, `CIC_G_BITOP, `CIC_G_RMWD: needs_mem = 1'b1;
      `CIC_G_DIR, `CIC_G_EXT: needs_mem = !(o[3:0] == `CIC_RM_STA || o[3:0] == `CIC_RM_STX
                                            || o[3:0] == `CIC_RM_JUMP || o[3:0] == `CIC_RM_CALL);
      default: needs_mem = 1'b0;
    endcase
  endfunction
  // Gaps in the function map behave as no-operation
  function automatic logic rmw_ok(input logic [3:0] f);
    case (f)
      4'h1, 4'h2, 4'h5, 4'hb, 4'he: rmw_ok = 1'b0;
      default: rmw_ok = 1'b1;
    endcase
  endfunction
  assign hi = r.op[7:4];
  assign lo = r.op[3:0];
  assign ex = (r.st == S_EXEC);
  assign ea = (hi == `CIC_G_EXT) ? {r.b1, r.b2} : {`CIC_DIRECT_HI, r.b1};
  assign mask = 8'h01 << r.op[3:1];
  assign bit_t = r.m[r.op[3:1]];
  assign bt_take = bit_t ^ r.op[0];
  assign bt_tgt = r.pc + {{8{r.b2[7]}}, r.b2};
  assign rel_tgt = r.pc + {{8{r.b1[7]}}, r.b1};
  assign prod = 16'(r.a) * 16'(r.x);
  // ==========================================
  // Branch conditions, odd opcode inverts
  always_comb begin
    rel_take = 1'b0;
    case (r.op[3:1])
      3'h0: rel_take = 1'b1;
      3'h1: rel_take = !(r.condition_flags_reg.c | r.condition_flags_reg.z);
      3'h2: rel_take = !r.condition_flags_reg.c;
      3'h3: rel_take = !r.condition_flags_reg.z;
      3'h4: rel_take = !r.condition_flags_reg.h;
      3'h5: rel_take = !r.condition_flags_reg.n;
      3'h6: rel_take = !r.condition_flags_reg.i;
      default: rel_take = !r.pin_s2;
    endcase
    rel_take = rel_take ^ r.op[0];
  end
  // ==========================================
  // Arithmetic operand steering
  always_comb begin
    alu_bus.rmw = (hi == `CIC_G_RMWD) || (hi == `CIC_G_RMWA) || (hi == `CIC_G_RMWX);
    alu_bus.fn = lo;
    alu_bus.cin = r.condition_flags_reg.c;
    alu_bus.a = (lo == `CIC_RM_CPX || lo == `CIC_RM_STX) ? r.x : r.a;
    case (hi)
      `CIC_G_RMWA: alu_bus.m = r.a;
      `CIC_G_RMWX: alu_bus.m = r.x;
      `CIC_G_IMM: alu_bus.m = r.b1;
      default: alu_bus.m = r.m;
    endcase
  end
  cic_alu u_alu (
    .p(alu_bus.alu)
  );
  // ==========================================
  // Sequencer
  always_comb begin
    r_nxt = r;
    r_nxt.rd = 1'b0;
    r_nxt.wr = 1'b0;
    // Pin is asynchronous, so two stages before use
    r_nxt.pin_s1 = irq_pin_n_in;
    r_nxt.pin_s2 = r.pin_s1;
    unique case (r.st)
      S_FETCH: begin
        r_nxt.rd = 1'b1;
        r_nxt.addr = r.pc;
        r_nxt.pc = r.pc + 16'h0001;
        r_nxt.st = S_OP;
      end
      S_OP: begin
        r_nxt.op = mem_rdata_in;
        r_nxt.st = S_EXEC;
        if (op_len(mem_rdata_in) != 2'h0) begin
          r_nxt.rd = 1'b1;
          r_nxt.addr = r.pc;
          r_nxt.pc = r.pc + 16'h0001;
          r_nxt.st = S_B1;
        end
      end
      S_B1: begin
        r_nxt.b1 = mem_rdata_in;
        r_nxt.st = S_EXEC;
        if (op_len(r.op) == 2'h2) begin
          r_nxt.rd = 1'b1;
          r_nxt.addr = r.pc;
          r_nxt.pc = r.pc + 16'h0001;
          r_nxt.st = S_B2;
        end else if (needs_mem(r.op)) begin
          r_nxt.rd = 1'b1;
          r_nxt.addr = {`CIC_DIRECT_HI, mem_rdata_in};
          r_nxt.st = S_MEM;
        end
      end
      S_B2: begin
        r_nxt.b2 = mem_rdata_in;
        r_nxt.st = S_EXEC;
        if (needs_mem(r.op)) begin
          r_nxt.rd = 1'b1;
          r_nxt.addr = (hi == `CIC_G_EXT) ? {r.b1, mem_rdata_in} : {`CIC_DIRECT_HI, r.b1};
          r_nxt.st = S_MEM;
        end
      end
      S_MEM: begin
        r_nxt.m = mem_rdata_in;
        r_nxt.st = S_EXEC;
      end
      S_EXEC: begin
        r_nxt.st = S_FETCH;
        case (hi)
          `CIC_G_BRBIT: begin
            r_nxt.condition_flags_reg.c = bit_t;
            if (bt_take) begin
              r_nxt.pc = bt_tgt;
            end
          end
          `CIC_G_BITOP: begin
            r_nxt.wr = 1'b1;
            r_nxt.addr = ea;
            r_nxt.wdata = r.op[0] ? (r.m & ~mask) : (r.m | mask);
          end
          `CIC_G_REL: begin
            if (rel_take) begin
              r_nxt.pc = rel_tgt;
            end
          end
          `CIC_G_RMWD, `CIC_G_RMWA, `CIC_G_RMWX: begin
            if (r.op == `CIC_OP_MULTIPLY) begin
              {r_nxt.x, r_nxt.a} = prod;
              r_nxt.condition_flags_reg.c = 1'b0;
              r_nxt.condition_flags_reg.h = 1'b0;
            end else if (rmw_ok(lo)) begin
              r_nxt.condition_flags_reg.n = alu_bus.res[7];
              r_nxt.condition_flags_reg.z = (alu_bus.res == 8'h00);
              if (alu_bus.cupd) begin
                r_nxt.condition_flags_reg.c = alu_bus.cout;
              end
              if (lo != `CIC_RMW_TEST) begin
                if (hi == `CIC_G_RMWD) begin
                  r_nxt.wr = 1'b1;
                  r_nxt.addr = ea;
                  r_nxt.wdata = alu_bus.res;
                end else if (hi == `CIC_G_RMWA) begin
                  r_nxt.a = alu_bus.res;
                end else begin
                  r_nxt.x = alu_bus.res;
                end
              end
            end
          end
          `CIC_G_CTL0, `CIC_G_CTL1: begin
            case (r.op)
              `CIC_OP_RTS: begin
                r_nxt.sp = r.sp + `CIC_SP_STEP;
                r_nxt.rd = 1'b1;
                r_nxt.addr = {`CIC_STACK_HI, r.sp + `CIC_SP_STEP};
                r_nxt.st = S_POP1;
              end
              `CIC_OP_STOP: begin
                r_nxt.osc_stop = 1'b1;
                r_nxt.irq_en = 1'b1;
                r_nxt.condition_flags_reg.i = 1'b0;
                r_nxt.st = S_HALT;
              end
              `CIC_OP_WAIT: begin
                r_nxt.clk_stop = 1'b1;
                r_nxt.condition_flags_reg.i = 1'b0;
                r_nxt.st = S_HALT;
              end
              `CIC_OP_COPY_AX: r_nxt.x = r.a;
              `CIC_OP_COPY_XA: r_nxt.a = r.x;
              `CIC_OP_CLC: r_nxt.condition_flags_reg.c = 1'b0;
              `CIC_OP_SEC: r_nxt.condition_flags_reg.c = 1'b1;
              `CIC_OP_CLI: r_nxt.condition_flags_reg.i = 1'b0;
              `CIC_OP_SEI: r_nxt.condition_flags_reg.i = 1'b1;
              default: r_nxt.st = S_FETCH;
            endcase
          end
          `CIC_G_IMM, `CIC_G_DIR, `CIC_G_EXT: begin
            // Immediate store or jump has no meaning; it acts as no-operation
            if (lo == `CIC_RM_JUMP) begin
              if (hi != `CIC_G_IMM) begin
                r_nxt.pc = ea;
              end
            end else if (lo == `CIC_RM_CALL) begin
              if (hi != `CIC_G_IMM) begin
                r_nxt.wr = 1'b1;
                r_nxt.addr = {`CIC_STACK_HI, r.sp};
                r_nxt.wdata = r.pc[7:0];
                r_nxt.sp = r.sp - `CIC_SP_STEP;
                r_nxt.st = S_PUSH;
              end
            end else if (!(hi == `CIC_G_IMM && (lo == `CIC_RM_STA || lo == `CIC_RM_STX))) begin
              r_nxt.condition_flags_reg.n = alu_bus.res[7];
              r_nxt.condition_flags_reg.z = (alu_bus.res == 8'h00);
              if (alu_bus.cupd) begin
                r_nxt.condition_flags_reg.c = alu_bus.cout;
              end
              if (alu_bus.hupd) begin
                r_nxt.condition_flags_reg.h = alu_bus.hout;
              end
              case (lo)
                `CIC_RM_COMPARE, `CIC_RM_CPX, `CIC_RM_BIT: r_nxt.st = S_FETCH;
                `CIC_RM_STA, `CIC_RM_STX: begin
                  r_nxt.wr = 1'b1;
                  r_nxt.addr = ea;
                  r_nxt.wdata = alu_bus.res;
                end
                `CIC_RM_LDX: r_nxt.x = alu_bus.res;
                default: r_nxt.a = alu_bus.res;
              endcase
            end
          end
          default: r_nxt.st = S_FETCH;
        endcase
      end
      S_PUSH: begin
        r_nxt.wr = 1'b1;
        r_nxt.addr = {`CIC_STACK_HI, r.sp};
        r_nxt.wdata = r.pc[15:8];
        r_nxt.sp = r.sp - `CIC_SP_STEP;
        r_nxt.pc = ea;
        r_nxt.st = S_FETCH;
      end
      S_POP1: begin
        r_nxt.pc[15:8] = mem_rdata_in;
        r_nxt.sp = r.sp + `CIC_SP_STEP;
        r_nxt.rd = 1'b1;
        r_nxt.addr = {`CIC_STACK_HI, r.sp + `CIC_SP_STEP};
        r_nxt.st = S_POP2;
      end
      S_POP2: begin
        r_nxt.pc[7:0] = mem_rdata_in;
        r_nxt.st = S_FETCH;
      end
      S_HALT: begin
        // Wake on a low pin level; no vectoring, execution resumes in line
        if (!r.pin_s2) begin
          r_nxt.osc_stop = 1'b0;
          r_nxt.clk_stop = 1'b0;
          r_nxt.st = S_FETCH;
        end
      end
    endcase
  end
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      r <= '0;
      r.st <= S_FETCH;
      r.pc <= `CIC_RESET_PC;
      r.sp <= `CIC_RESET_SP;
      r.condition_flags_reg.i <= 1'b1;
      r.pin_s1 <= 1'b1;
      r.pin_s2 <= 1'b1;
    end else begin
      r <= r_nxt;
    end
  end
  assign mem_addr_out = r.addr;
  assign mem_rd_out = r.rd;
  assign mem_wr_out = r.wr;
  assign mem_wdata_out = r.wdata;
  assign pc_out = r.pc;
  assign acc_out = r.a;
  assign idx_out = r.x;
  assign ccr_out = r.condition_flags_reg;
  assign osc_stop_out = r.osc_stop;
  assign cpu_clk_stop_out = r.clk_stop;
  assign irq_pin_en_out = r.irq_en;
  // ==========================================
  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);
  a_bit_carry: assert property (ex && hi == `CIC_G_BRBIT |=> r.condition_flags_reg.c == $past(bit_t))
    else $error("tested bit not copied to carry");
  a_bit_branch: assert property (ex && hi == `CIC_G_BRBIT |=>
    r.pc == ($past(bt_take) ? $past(bt_tgt) : $past(r.pc)))
    else $error("bit test branch target wrong");
  a_brbit_len: assert property (r.st == S_OP && mem_rdata_in[7:4] == `CIC_G_BRBIT |=>
    r.st == S_B1 ##1 r.st == S_B2 ##1 r.st == S_MEM ##1 r.st == S_EXEC)
    else $error("bit test branch is not three bytes");
  a_rel_branch: assert property (ex && hi == `CIC_G_REL |=>
    r.pc == ($past(rel_take) ? $past(rel_tgt) : $past(r.pc)))
    else $error("relative branch wrong");
  a_pin_branch: assert property (ex && r.op == `CIC_OP_PIN_HIGH && r.pin_s2 |=> r.pc == $past(rel_tgt))
    else $error("pin high branch not taken");
  a_bitop_write: assert property (ex && hi == `CIC_G_BITOP |=>
    mem_wr_out && mem_addr_out == {`CIC_DIRECT_HI, $past(r.b1)} && !mem_rd_out)
    else $error("bit set or clear not written to direct page");
  a_tst_nowrite: assert property (ex && hi == `CIC_G_RMWD && lo == `CIC_RMW_TEST |=>
    !mem_wr_out ##1 !mem_wr_out)
    else $error("test operation wrote back");
  a_rmw_write: assert property (ex && hi == `CIC_G_RMWD && rmw_ok(lo) && lo != `CIC_RMW_TEST |=>
    mem_wr_out && mem_addr_out == $past(ea) && mem_wdata_out == $past(alu_bus.res))
    else $error("read-modify-write result not written back");
  a_cmp_keep: assert property (ex && hi >= `CIC_G_IMM && hi <= `CIC_G_EXT &&
    (lo == `CIC_RM_COMPARE || lo == `CIC_RM_CPX || lo == `CIC_RM_BIT) |=>
    !mem_wr_out && $stable(r.a) && $stable(r.x))
    else $error("compare changed a register or memory");
  a_mul_split: assert property (ex && r.op == `CIC_OP_MULTIPLY |=> {r.x, r.a} == $past(prod))
    else $error("multiply result misplaced");
  a_copy_regs: assert property (ex && r.op == `CIC_OP_COPY_AX |=> r.x == $past(r.a) && $stable(r.a))
    else $error("accumulator not copied to index");
  a_rot_carry: assert property (ex && hi == `CIC_G_RMWA && lo == `CIC_RMW_ROTL |=>
    r.a[0] == $past(r.condition_flags_reg.c) && r.condition_flags_reg.c == $past(r.a[7]))
    else $error("rotate did not pass through carry");
  a_stop_osc: assert property (ex && r.op == `CIC_OP_STOP |=> osc_stop_out && irq_pin_en_out)
    else $error("halt did not stop oscillator");
  a_wait_clk: assert property (ex && r.op == `CIC_OP_WAIT |=> cpu_clk_stop_out && !r.condition_flags_reg.i)
    else $error("idle did not stop clock or clear mask");
  a_jump_pc: assert property (ex && hi != `CIC_G_IMM && hi >= `CIC_G_DIR && hi <= `CIC_G_EXT &&
    lo == `CIC_RM_JUMP |=> r.pc == $past(ea))
    else $error("jump target wrong");
  c_bit_taken: cover property (ex && hi == `CIC_G_BRBIT && bt_take);
  c_halt_wake: cover property (r.st == S_HALT ##1 r.st == S_FETCH);
  c_subroutine: cover property (r.st == S_PUSH);
  c_multiply: cover property (ex && r.op == `CIC_OP_MULTIPLY);
endmodule
`default_nettype wire

// [cic_mem_model.sv]
// Memory and peripheral space model on the core's bus
`timescale 1ns/1ps
`default_nettype none
module cic_mem_model (
  input wire logic clk_in,
  input wire logic [15:0] addr_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);
  // ==========================================
  // Storage; read answers within the strobe cycle, since the core latches it there
  logic [7:0] m [0:1023];
  // All locations readable, so read-modify-write is always legal
  always @(posedge clk_in) begin
    if (wr_in) begin
      m[addr_in[9:0]] <= wdata_in;
    end
  end
  // Idle bus shows the inverse so stale data is never mistaken for an answer
  assign rdata_out = rd_in ? m[addr_in[9:0]] : ~m[addr_in[9:0]];
endmodule
`default_nettype wire

// [cpu_instruction_class_execution_bench.sv]
// Self-checking bench for the instruction class execution core
`timescale 1ns/1ps
`default_nettype none
module cpu_instruction_class_execution_bench;
  import cic_pkg::*;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic irq_pin_n_in = 1'b1;
  logic [7:0] mem_rdata_in, mem_wdata_out, acc_out, idx_out;
  logic [15:0] mem_addr_out, pc_out;
  logic mem_rd_out, mem_wr_out, osc_stop_out, cpu_clk_stop_out, irq_pin_en_out;
  cic_ccr_t ccr_out;
  int err_total = 0;
  int comparisons = 0;
  int wr_cnt = 0;
  // ==========================================
  // Clock, design and memory
  initial begin
    forever #50 clk_in = ~clk_in;
  end
  cic_core uut (.clk_in(clk_in), .arst_n_in(arst_n_in), .irq_pin_n_in(irq_pin_n_in),
    .mem_rdata_in(mem_rdata_in), .mem_addr_out(mem_addr_out), .mem_rd_out(mem_rd_out),
    .mem_wr_out(mem_wr_out), .mem_wdata_out(mem_wdata_out), .pc_out(pc_out), .acc_out(acc_out),
    .idx_out(idx_out), .ccr_out(ccr_out), .osc_stop_out(osc_stop_out),
    .cpu_clk_stop_out(cpu_clk_stop_out), .irq_pin_en_out(irq_pin_en_out));
  cic_mem_model mem (.clk_in(clk_in), .addr_in(mem_addr_out), .rd_in(mem_rd_out),
    .wr_in(mem_wr_out), .wdata_in(mem_wdata_out), .rdata_out(mem_rdata_in));
  always @(posedge clk_in) begin
    if (mem_wr_out === 1'b1) begin
      wr_cnt++;
    end
  end
  // ==========================================
  // Shared tasks
  task automatic final_report();
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // Reset held three cycles, program placed at the reset address
  task automatic boot(input logic [7:0] p []);
    arst_n_in = 1'b0;
    for (int i = 0; i < p.size(); i++) begin
      mem.m[256 + i] = p[i];
    end
    repeat (3) @(negedge clk_in);
    arst_n_in = 1'b1;
    wr_cnt = 0;
  endtask
  task automatic wait_pc(input logic [15:0] stop);
    int n;
    n = 0;
    while (pc_out !== stop && n < 300) begin
      @(negedge clk_in);
      n++;
    end
    if (n == 300) begin
      check(pc_out, stop, "program never reached end");
      final_report();
    end
    repeat (4) @(negedge clk_in);
  endtask
  task automatic wait_stop(input bit osc, input logic v);
    int n;
    n = 0;
    while ((osc ? osc_stop_out : cpu_clk_stop_out) !== v && n < 300) begin
      @(negedge clk_in);
      n++;
    end
    if (n == 300) begin
      check(16'h0, 16'h1, "stop level timeout");
      final_report();
    end
  endtask
  // ==========================================
  // Scenarios
  task automatic t_regmem();
    mem.m[16'h40] = 8'h5a;
    boot('{8'hb6, 8'h40, 8'ha1, 8'h5a, 8'h97, 8'h4f, 8'h9f, 8'ha1, 8'h00, 8'h20, 8'hfe});
    wait_pc(16'h0109);
    check(16'(acc_out), 16'h005a, "acc after copies");
    check(16'(idx_out), 16'h005a, "index copy");
    check(16'(ccr_out.z), 16'h0, "compare flags");
    check(16'(wr_cnt), 16'h0, "compare wrote");
    $display("test regmem done");
  endtask
  task automatic t_rmw();
    mem.m[16'h41] = 8'h81;
    boot('{8'h99, 8'h36, 8'h41, 8'h3d, 8'h41, 8'h20, 8'hfe});
    wait_pc(16'h0105);
    check(16'(mem.m[16'h41]), 16'h00c0, "rotate result");
    check(16'(ccr_out.c), 16'h1, "rotate carry out");
    check(16'(ccr_out.n), 16'h1, "test flags");
    check(16'(wr_cnt), 16'h1, "test wrote back");
    $display("test rmw done");
  endtask
  task automatic t_bits();
    mem.m[16'h42] = 8'h00;
    boot('{8'h14, 8'h42, 8'h05, 8'h42, 8'h02, 8'h04, 8'h42, 8'h02, 8'h4c, 8'h4c,
      8'h15, 8'h42, 8'h20, 8'hfe});
    wait_pc(16'h010c);
    check(16'(acc_out), 16'h0000, "bit branch skip");
    check(16'(mem.m[16'h42]), 16'h0000, "bit set then clear");
    check(16'(ccr_out.c), 16'h1, "tested bit to carry");
    $display("test bits done");
  endtask
  task automatic t_jump();
    irq_pin_n_in = 1'b1;
    boot('{8'h2e, 8'h02, 8'h4c, 8'h2f, 8'h01, 8'h4c, 8'hcc, 8'h01, 8'h0b, 8'h4c, 8'h4c,
      8'h20, 8'hfe});
    wait_pc(16'h010b);
    check(16'(acc_out), 16'h0001, "pin branches and jump");
    $display("test jump done");
  endtask
  task automatic t_ctl();
    boot('{8'h8f, 8'h8e, 8'h20, 8'hfe});
    wait_stop(1'b0, 1'b1);
    check(16'(ccr_out.i), 16'h0, "idle mask");
    irq_pin_n_in = 1'b0;
    wait_stop(1'b0, 1'b0);
    irq_pin_n_in = 1'b1;
    wait_stop(1'b1, 1'b1);
    check(16'(irq_pin_en_out), 16'h1, "halt pin enable");
    irq_pin_n_in = 1'b0;
    wait_stop(1'b1, 1'b0);
    irq_pin_n_in = 1'b1;
    $display("test control done");
  endtask
  task automatic t_multiply();
    boot('{8'ha6, 8'hf0, 8'hae, 8'h11, 8'h42, 8'h49, 8'h20, 8'hfe});
    wait_pc(16'h0106);
    check({idx_out, acc_out}, 16'h0fe0, "product bytes then rotate");
    check(16'(ccr_out.c), 16'h1, "rotate left carry out");
    $display("test multiply done");
  endtask
  initial begin
    @(negedge clk_in);
    t_regmem();
    t_rmw();
    t_bits();
    t_jump();
    t_ctl();
    t_multiply();
    final_report();
  end
endmodule
`default_nettype wire
